/* File: bsc_pkg.sv */
// Notes on behaviour
// - Indirect call: PC low from Z, high cleared
// - Extended indirect call: high bits from register
// - Equal compare skips next instruction, no flags
// - Skip when register bit reads zero
// - Skip when register bit reads one
// - Skip when I/O bit is zero, 2-4 cycles
// - Skip when I/O bit is one, 2-4 cycles
// - Status-set branch jumps to PC plus k plus one
// - Status-clear branch jumps when bit is zero
// - Carry-clear branch jumps when carry is zero
// - Same-or-higher branch equals carry-clear branch
// - Signed greater-or-equal jumps when N xor V zero
// - Signed less-than jumps when N xor V one
// - Half-carry branches on H set or clear
// - Transfer-bit branches on T set or clear
// - Overflow branches on V set or clear
// - Interrupt-enable branches on I set or clear
package bsc_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_OPER = 8'h04;
  localparam logic [7:0] OFS_ADDR = 8'h08;
  localparam logic [7:0] OFS_STACK = 8'h0C;
  localparam logic [7:0] OFS_PC = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_CONFIG = 8'h1C;
  localparam logic [7:0] OFS_LINK = 8'h20;
  localparam logic [7:0] OFS_RESULT = 8'h24;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CTL_OP = 0;
  localparam int CTL_SEL = 8;
  localparam int CTL_K = 16;
  localparam int CTL_IMM = 24;
  localparam int OPR_RD = 0;
  localparam int OPR_RR = 8;
  localparam int OPR_IO = 16;
  localparam int OPR_RRH = 24;
  localparam int CFG_WIDE = 0;
  localparam int CFG_LONG = 1;
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;
  // ------------------------------------------------------------
  // Reset values and cycle counts
  // ------------------------------------------------------------
  localparam logic [21:0] PC_RST = 22'h000000;
  localparam logic [7:0] FLG_RST = 8'h00;
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_FOUR = 3'h4;
  localparam logic [2:0] CYC_FIVE = 3'h5;
  typedef enum logic [5:0] {
    OP_NOP = 6'h00, OP_IND_CALL = 6'h01, OP_EXT_CALL = 6'h02, OP_ABS_CALL = 6'h03,
    OP_SUB_EXIT = 6'h04, OP_IRQ_EXIT = 6'h05, OP_EQ_SKIP = 6'h06, OP_CMP = 6'h07,
    OP_CMPC = 6'h08, OP_CMPI = 6'h09, OP_RBZ = 6'h0A, OP_RBO = 6'h0B,
    OP_IOBZ = 6'h0C, OP_IOBO = 6'h0D, OP_SSET = 6'h0E, OP_SCLR = 6'h0F,
    OP_ZSET = 6'h10, OP_ZCLR = 6'h11, OP_CSET = 6'h12, OP_CCLR = 6'h13,
    OP_SAMEH = 6'h14, OP_LOWER = 6'h15, OP_NEG = 6'h16, OP_POS = 6'h17,
    OP_SGE = 6'h18, OP_SLT = 6'h19, OP_HSET = 6'h1A, OP_HCLR = 6'h1B,
    OP_TSET = 6'h1C, OP_TCLR = 6'h1D, OP_VSET = 6'h1E, OP_VCLR = 6'h1F,
    OP_IEN = 6'h20, OP_IDIS = 6'h21, OP_MOV = 6'h22, OP_PAIR_COPY = 6'h23,
    OP_LOAD_CONST = 6'h24
  } bsc_op_e;
  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_EXEC = 1'b1} bsc_state_e;
endpackage : bsc_pkg

/* File: bsc_core.sv */
`timescale 1ns/10ps
`default_nettype none
module bsc_core (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import bsc_pkg::*;
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  bsc_state_e state;
  logic [2:0] cnt;
  logic [31:0] oper;
  logic [21:0] call_addr;
  logic [21:0] ret_addr;
  logic [21:0] pc;
  logic [7:0] flags;
  logic [1:0] cfg;
  logic [21:0] link;
  logic [15:0] result;
  logic [2:0] last_cyc;
  logic skip_tk;
  logic br_tk;
  logic [21:0] res_pc;
  logic [7:0] res_flags;
  logic [21:0] res_link;
  logic [15:0] res_result;
  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire busy = (state == ST_EXEC);
  wire acc = psel & penable;
  wire first = acc & ~pready;
  wire done = acc & pready;
  wire wr_ok = done & pwrite & ~pslverr;
  wire hit_ctrl = (paddr == OFS_CTRL);
  wire hit_oper = (paddr == OFS_OPER);
  wire hit_addr = (paddr == OFS_ADDR);
  wire hit_stack = (paddr == OFS_STACK);
  wire hit_pc = (paddr == OFS_PC);
  wire hit_flags = (paddr == OFS_FLAGS);
  wire hit_status = (paddr == OFS_STATUS);
  wire hit_cfg = (paddr == OFS_CONFIG);
  wire hit_link = (paddr == OFS_LINK);
  wire hit_res = (paddr == OFS_RESULT);
  wire mapped = hit_ctrl | hit_oper | hit_addr | hit_stack | hit_pc | hit_flags
              | hit_status | hit_cfg | hit_link | hit_res;
  wire [5:0] op = pwdata[CTL_OP +: 6];
  wire [2:0] sel = pwdata[CTL_SEL +: 3];
  wire [6:0] koff = pwdata[CTL_K +: 7];
  wire [7:0] imm = pwdata[CTL_IMM +: 8];
  wire [7:0] rd = oper[OPR_RD +: 8];
  wire [7:0] rr = oper[OPR_RR +: 8];
  wire [7:0] io = oper[OPR_IO +: 8];
  wire [7:0] rrh = oper[OPR_RRH +: 8];
  wire wide = cfg[CFG_WIDE];
  wire nlong = cfg[CFG_LONG];
  wire legal;
  // Refusing every write while busy keeps operands stable until commit
  wire err = ~mapped | (pwrite & busy) | (pwrite & hit_ctrl & ~legal);
  wire issue = wr_ok & hit_ctrl;
  wire commit = busy & (cnt == CYC_ONE);
  // ------------------------------------------------------------
  // Arithmetic for flags-only subtraction
  // ------------------------------------------------------------
  wire is_cmpi = (op == OP_CMPI);
  wire is_cmpc = (op == OP_CMPC);
  wire [7:0] sub_b = is_cmpi ? imm : rr;
  wire sub_cin = is_cmpc & flags[FLG_C];
  wire [7:0] diff = rd - sub_b - {7'h00, sub_cin};
  wire sub_h = (~rd[3] & sub_b[3]) | (sub_b[3] & diff[3]) | (diff[3] & ~rd[3]);
  wire sub_c = (~rd[7] & sub_b[7]) | (sub_b[7] & diff[7]) | (diff[7] & ~rd[7]);
  wire sub_v = (rd[7] & ~sub_b[7] & ~diff[7]) | (~rd[7] & sub_b[7] & diff[7]);
  // Compare with carry keeps Z only when earlier bytes were also equal
  wire sub_z = (diff == 8'h00) & (~is_cmpc | flags[FLG_Z]);
  wire [21:0] pc1 = pc + 22'h000001;
  wire [21:0] kx = {{15{koff[6]}}, koff};
  wire [21:0] br_tgt = pc + kx + 22'h000001;
  wire [21:0] skip_pc = pc + (nlong ? 22'h000003 : 22'h000002);
  wire nv = flags[FLG_N] ^ flags[FLG_V];
  // ------------------------------------------------------------
  // Instruction decode
  // ------------------------------------------------------------
  logic [21:0] next_pc;
  logic [7:0] next_flags;
  logic [2:0] next_cyc;
  logic [21:0] next_link;
  logic [15:0] next_result;
  logic next_skip;
  logic next_take;
  logic next_isbr;
  logic next_legal;
  logic [2:0] base_cyc;
  always_comb begin
    next_pc = pc1;
    next_flags = flags;
    base_cyc = CYC_ONE;
    next_link = link;
    next_result = result;
    next_skip = 1'b0;
    next_take = 1'b0;
    next_isbr = 1'b1;
    next_legal = 1'b1;
    unique case (op)
      OP_IND_CALL: begin
        next_pc = {6'h00, call_addr[15:0]};
        base_cyc = wide ? CYC_THREE : CYC_TWO;
        next_link = pc1;
        next_isbr = 1'b0;
      end
      OP_EXT_CALL: begin
        next_pc = call_addr;
        base_cyc = CYC_THREE;
        next_link = pc1;
        next_isbr = 1'b0;
      end
      OP_ABS_CALL: begin
        // Two-word instruction, so the return address is two ahead
        next_pc = call_addr;
        base_cyc = wide ? CYC_FOUR : CYC_THREE;
        next_link = pc + 22'h000002;
        next_isbr = 1'b0;
      end
      OP_SUB_EXIT: begin
        next_pc = ret_addr;
        base_cyc = wide ? CYC_FIVE : CYC_FOUR;
        next_isbr = 1'b0;
      end
      OP_IRQ_EXIT: begin
        next_pc = ret_addr;
        next_flags[FLG_I] = 1'b1;
        base_cyc = wide ? CYC_FIVE : CYC_FOUR;
        next_isbr = 1'b0;
      end
      OP_EQ_SKIP: begin
        next_skip = (rd == rr);
        next_isbr = 1'b0;
      end
      OP_CMP, OP_CMPC, OP_CMPI: begin
        next_flags[FLG_Z] = sub_z;
        next_flags[FLG_C] = sub_c;
        next_flags[FLG_N] = diff[7];
        next_flags[FLG_V] = sub_v;
        next_flags[FLG_S] = diff[7] ^ sub_v;
        next_flags[FLG_H] = sub_h;
        next_isbr = 1'b0;
      end
      OP_RBZ: begin
        next_skip = ~rr[sel];
        next_isbr = 1'b0;
      end
      OP_RBO: begin
        next_skip = rr[sel];
        next_isbr = 1'b0;
      end
      OP_IOBZ: begin
        next_skip = ~io[sel];
        base_cyc = CYC_TWO;
        next_isbr = 1'b0;
      end
      OP_IOBO: begin
        next_skip = io[sel];
        base_cyc = CYC_TWO;
        next_isbr = 1'b0;
      end
      OP_SSET: next_take = flags[sel];
      OP_SCLR: next_take = ~flags[sel];
      OP_ZSET: next_take = flags[FLG_Z];
      OP_ZCLR: next_take = ~flags[FLG_Z];
      OP_CSET, OP_LOWER: next_take = flags[FLG_C];
      OP_CCLR: next_take = ~flags[FLG_C];
      OP_SAMEH: next_take = ~flags[FLG_C];
      OP_NEG: next_take = flags[FLG_N];
      OP_POS: next_take = ~flags[FLG_N];
      OP_SGE: next_take = ~nv;
      OP_SLT: next_take = nv;
      OP_HSET: next_take = flags[FLG_H];
      OP_HCLR: next_take = ~flags[FLG_H];
      OP_TSET: next_take = flags[FLG_T];
      OP_TCLR: next_take = ~flags[FLG_T];
      OP_VSET: next_take = flags[FLG_V];
      OP_VCLR: next_take = ~flags[FLG_V];
      OP_IEN: next_take = flags[FLG_I];
      OP_IDIS: next_take = ~flags[FLG_I];
      OP_MOV: begin
        next_result = {8'h00, rr};
        next_isbr = 1'b0;
      end
      OP_PAIR_COPY: begin
        next_result = {rrh, rr};
        next_isbr = 1'b0;
      end
      OP_LOAD_CONST: begin
        next_result = {8'h00, imm};
        next_isbr = 1'b0;
      end
      OP_NOP: next_isbr = 1'b0;
      default: begin
        next_legal = 1'b0;
        next_isbr = 1'b0;
      end
    endcase
  end
  assign legal = next_legal;
  // Skipping a two-word instruction costs one more cycle than a short one
  wire [2:0] skip_extra = nlong ? CYC_TWO : CYC_ONE;
  wire [21:0] fin_pc = next_skip ? skip_pc : (next_take ? br_tgt : next_pc);
  wire [2:0] fin_cyc = next_skip ? (base_cyc + skip_extra)
                     : (next_take ? CYC_TWO : base_cyc);
  // ------------------------------------------------------------
  // Execution sequencing
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      cnt <= CYC_ONE;
    end else if (issue) begin
      state <= ST_EXEC;
      cnt <= fin_cyc;
    end else if (commit) begin
      state <= ST_IDLE;
    end else if (busy) begin
      cnt <= cnt - CYC_ONE;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      res_pc <= PC_RST;
      res_flags <= FLG_RST;
      res_link <= PC_RST;
      res_result <= 16'h0000;
      last_cyc <= 3'h0;
      skip_tk <= 1'b0;
      br_tk <= 1'b0;
    end else if (issue) begin
      res_pc <= fin_pc;
      res_flags <= next_flags;
      res_link <= next_link;
      res_result <= next_result;
      last_cyc <= fin_cyc;
      skip_tk <= next_skip;
      br_tk <= next_take;
    end
  end
  // ------------------------------------------------------------
  // Architectural state: software writes when idle, commit when busy
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pc <= PC_RST;
      flags <= FLG_RST;
      link <= PC_RST;
      result <= 16'h0000;
    end else if (commit) begin
      pc <= res_pc;
      flags <= res_flags;
      link <= res_link;
      result <= res_result;
    end else if (wr_ok & hit_pc) begin
      pc <= pwdata[21:0];
    end else if (wr_ok & hit_flags) begin
      flags <= pwdata[7:0];
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      oper <= 32'h00000000;
      call_addr <= PC_RST;
      ret_addr <= PC_RST;
      cfg <= 2'h0;
    end else begin
      if (wr_ok & hit_oper) oper <= pwdata;
      if (wr_ok & hit_addr) call_addr <= pwdata[21:0];
      if (wr_ok & hit_stack) ret_addr <= pwdata[21:0];
      if (wr_ok & hit_cfg) cfg <= pwdata[1:0];
    end
  end
  // ------------------------------------------------------------
  // APB slave: one wait state on every transfer
  // ------------------------------------------------------------
  wire [31:0] rmux = hit_oper ? oper
                   : hit_addr ? {10'h000, call_addr}
                   : hit_stack ? {10'h000, ret_addr}
                   : hit_pc ? {10'h000, pc}
                   : hit_flags ? {24'h000000, flags}
                   : hit_status ? {21'h000000, last_cyc, 5'h00, br_tk, skip_tk, busy}
                   : hit_cfg ? {30'h00000000, cfg}
                   : hit_link ? {10'h000, link}
                   : hit_res ? {16'h0000, result}
                   : 32'h00000000;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= first;
      pslverr <= first & err;
      if (first & ~pwrite) prdata <= rmux;
    end
  end
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_ind_call_pc: assert property (
    issue && op == OP_IND_CALL |-> ##[2:3] (commit ##1 (pc[21:16] == 6'h00
      && pc[15:0] == call_addr[15:0] && flags == $past(flags))))
    else $error("indirect call target or flags wrong");
  chk_ext_call_cyc: assert property (
    issue && op == OP_EXT_CALL |=> busy [*3] ##1 (!busy && pc == call_addr))
    else $error("extended indirect call timing or target wrong");
  chk_eq_skip_pc: assert property (
    issue && op == OP_EQ_SKIP && rd == rr && !nlong
      |=> busy [*2] ##1 (!busy && pc == $past(pc, 3) + 22'h000002))
    else $error("equal skip did not advance by two");
  chk_rbz_noskip: assert property (
    issue && op == OP_RBZ && rr[sel] |=> busy ##1 (!busy && pc == $past(pc, 2) + 22'h000001))
    else $error("register bit skip taken wrongly");
  chk_rbo_long: assert property (
    issue && op == OP_RBO && rr[sel] && nlong
      |=> busy [*3] ##1 (!busy && pc == $past(pc, 4) + 22'h000003))
    else $error("register bit set skip wrong");
  chk_io_skip_cyc: assert property (
    issue && (op == OP_IOBZ || op == OP_IOBO) |=> busy [*2])
    else $error("io bit skip shorter than two cycles");
  chk_branch_taken: assert property (
    issue && next_isbr && next_take |=> busy [*2] ##1 (!busy && pc == $past(br_tgt, 3)))
    else $error("taken branch timing or target wrong");
  chk_branch_idle: assert property (
    issue && next_isbr && !next_take |=> busy ##1 (!busy && pc == $past(pc1, 2)))
    else $error("untaken branch wrong");
  chk_cmp_noresult: assert property (
    issue && op == OP_CMP |=> busy ##1 (flags[FLG_Z] == (rd == rr) && $stable(result)))
    else $error("compare touched result or zero flag wrong");
  chk_irq_exit_ie: assert property (
    issue && op == OP_IRQ_EXIT |-> ##[5:6] (!busy && flags[FLG_I] && pc == ret_addr))
    else $error("interrupt return did not restore");
  chk_apb_wait_one: assert property (first |=> pready)
    else $error("apb answer late");
  cov_skip_long: cover property (issue && next_skip && nlong);
  cov_branch_taken: cover property (issue && next_isbr && next_take);
  cov_irq_exit: cover property (issue && op == OP_IRQ_EXIT);
  cov_busy_refuse: cover property (done && pwrite && busy);
endmodule : bsc_core
`default_nettype wire

/* File: branch_skip_call_control_test.sv */
`timescale 1ns/10ps
`default_nettype none
module branch_skip_call_control_test;
  import bsc_pkg::*;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, err, tk, sk, io;
  logic [7:0] paddr, fv;
  logic [31:0] pwdata, prdata, rdat, stat;
  logic [2:0] sel;
  logic [7:0] fl_tab [4] = '{8'h00, 8'hFF, 8'h55, 8'hAA};
  logic [5:0] sk_ops [5] = '{6'h06, 6'h0A, 6'h0B, 6'h0C, 6'h0D};
  int errors, tests_run, cycles;

  bsc_core dut_u (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------------------
  // Bus and check helpers
  // ------------------------------------------------------------
  task automatic give_verdict;
    $display("compares %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  // Hang guard: the whole run needs a few thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rd_chk

  function automatic logic [31:0] ctl(input logic [5:0] op, input logic [2:0] s,
                                      input logic [6:0] k, input logic [7:0] kk);
    return {kk, 1'b0, k, 5'h00, s, 2'b00, op};
  endfunction : ctl

  function automatic logic taken(input logic [5:0] op, input logic [7:0] f,
                                 input logic [2:0] s);
    case (op)
      6'h0E: return f[s];
      6'h0F: return !f[s];
      6'h10: return f[1];
      6'h11: return !f[1];
      6'h12, 6'h15: return f[0];
      6'h13, 6'h14: return !f[0];
      6'h16: return f[2];
      6'h17: return !f[2];
      6'h18: return !(f[2] ^ f[3]);
      6'h19: return f[2] ^ f[3];
      6'h1A: return f[5];
      6'h1B: return !f[5];
      6'h1C: return f[6];
      6'h1D: return !f[6];
      6'h1E: return f[3];
      6'h1F: return !f[3];
      6'h20: return f[7];
      default: return !f[7];
    endcase
  endfunction : taken

  // Issue, wait out busy, then compare cycle count, PC and flags
  task automatic run(input logic [21:0] pc0, input logic [7:0] f0, input logic [31:0] c,
                     input logic [21:0] pc_x, input logic [7:0] f_x, input logic [2:0] c_x);
    apb(1'b1, OFS_PC, {10'h000, pc0});
    apb(1'b1, OFS_FLAGS, {24'h000000, f0});
    apb(1'b1, OFS_CTRL, c);
    do apb(1'b0, OFS_STATUS, 32'h0); while (rdat[0] !== 1'b0);
    // Keep the status word: the reads below overwrite the read buffer
    stat = rdat;
    chk({29'h0, stat[10:8]}, {29'h0, c_x});
    rd_chk(OFS_PC, {10'h000, pc_x});
    rd_chk(OFS_FLAGS, {24'h000000, f_x});
  endtask : run

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd_chk(OFS_PC, 32'h0);
    rd_chk(OFS_FLAGS, 32'h0);
    rd_chk(OFS_STATUS, 32'h0);
    rd_chk(OFS_CONFIG, 32'h0);
    $display("test reset values done");

    for (int op = 'h0E; op <= 'h21; op++) begin
      for (int i = 0; i < 4; i++) begin
        fv = fl_tab[i];
        sel = op[2:0] ^ i[2:0];
        tk = taken(op[5:0], fv, sel);
        run(22'h000100, fv, ctl(op[5:0], sel, 7'h7D, 8'h00), tk ? 22'h0000FE : 22'h000101,
            fv, tk ? CYC_TWO : CYC_ONE);
        chk({31'h0, stat[2]}, 32'(tk));
      end
    end
    // Forward jump that wraps the 22-bit counter
    run(22'h3FFFC0, 8'h00, ctl(OP_ZCLR, 3'h0, 7'h3F, 8'h00), 22'h000000, 8'h00, CYC_TWO);
    $display("test branches done");

    for (int j = 0; j < 5; j++) begin
      for (int lg = 0; lg < 2; lg++) begin
        for (int bv = 0; bv < 2; bv++) begin
          io = (sk_ops[j] == 6'h0C) || (sk_ops[j] == 6'h0D);
          sk = ((sk_ops[j] == 6'h0A) || (sk_ops[j] == 6'h0C)) ? (bv == 0) : (bv == 1);
          apb(1'b1, OFS_CONFIG, {30'h0, lg[0], 1'b0});
          apb(1'b1, OFS_OPER, (bv == 1) ? 32'h00FFFFFF : 32'h0000005A);
          run(22'h000200, 8'h3C, ctl(sk_ops[j], 3'h5, 7'h00, 8'h00),
              22'(32'h200 + (sk ? 2 + lg : 1)), 8'h3C,
              3'((io ? 2 : 1) + (sk ? 1 + lg : 0)));
          chk({31'h0, stat[1]}, 32'(sk));
        end
      end
    end
    $display("test skips done");

    apb(1'b1, OFS_ADDR, 32'h003ABCD);
    apb(1'b1, OFS_STACK, 32'h002468A);
    for (int w = 0; w < 2; w++) begin
      apb(1'b1, OFS_CONFIG, 32'(w));
      run(22'h000300, 8'h3C, ctl(OP_IND_CALL, 3'h0, 7'h00, 8'h00), 22'h00ABCD, 8'h3C, 3'(2 + w));
      rd_chk(OFS_LINK, 32'h301);
      run(22'h000300, 8'h3C, ctl(OP_EXT_CALL, 3'h0, 7'h00, 8'h00), 22'h03ABCD, 8'h3C, CYC_THREE);
      rd_chk(OFS_LINK, 32'h301);
      run(22'h000300, 8'h3C, ctl(OP_ABS_CALL, 3'h0, 7'h00, 8'h00), 22'h03ABCD, 8'h3C, 3'(3 + w));
      rd_chk(OFS_LINK, 32'h302);
      run(22'h000300, 8'h3C, ctl(OP_SUB_EXIT, 3'h0, 7'h00, 8'h00), 22'h02468A, 8'h3C, 3'(4 + w));
      run(22'h000300, 8'h3C, ctl(OP_IRQ_EXIT, 3'h0, 7'h00, 8'h00), 22'h02468A, 8'hBC, 3'(4 + w));
    end
    $display("test calls and returns done");

    apb(1'b1, OFS_OPER, 32'h99002010);
    run(22'h000040, 8'hC0, ctl(OP_CMP, 3'h0, 7'h00, 8'h00), 22'h000041, 8'hD5, CYC_ONE);
    rd_chk(OFS_RESULT, 32'h0);
    apb(1'b1, OFS_OPER, 32'h99000505);
    run(22'h000040, 8'h03, ctl(OP_CMPC, 3'h0, 7'h00, 8'h00), 22'h000041, 8'h35, CYC_ONE);
    run(22'h000040, 8'hC0, ctl(OP_CMPI, 3'h0, 7'h00, 8'h05), 22'h000041, 8'hC2, CYC_ONE);
    rd_chk(OFS_OPER, 32'h99000505);
    apb(1'b1, OFS_OPER, 32'h99007705);
    run(22'h000040, 8'hA5, ctl(OP_MOV, 3'h0, 7'h00, 8'h00), 22'h000041, 8'hA5, CYC_ONE);
    rd_chk(OFS_RESULT, 32'h0077);
    run(22'h000040, 8'h5A, ctl(OP_PAIR_COPY, 3'h0, 7'h00, 8'h00), 22'h000041, 8'h5A, CYC_ONE);
    rd_chk(OFS_RESULT, 32'h9977);
    run(22'h000040, 8'hFF, ctl(OP_LOAD_CONST, 3'h0, 7'h00, 8'h42), 22'h000041, 8'hFF, CYC_ONE);
    rd_chk(OFS_RESULT, 32'h0042);
    // Empty operation: one cycle, next address, nothing else touched
    run(22'h000040, 8'h81, ctl(OP_NOP, 3'h0, 7'h00, 8'h00), 22'h000041, 8'h81, CYC_ONE);
    rd_chk(OFS_RESULT, 32'h0042);
    $display("test compares and copies done");

    // Refused accesses leave state alone
    apb(1'b0, 8'h28, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 8'h28, 32'h1234);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, OFS_STATUS, 32'hFFFF);
    chk({31'h0, err}, 32'h0);
    apb(1'b1, OFS_PC, 32'h50);
    apb(1'b1, OFS_CTRL, ctl(6'h25, 3'h0, 7'h00, 8'h00));
    chk({31'h0, err}, 32'h1);
    rd_chk(OFS_PC, 32'h50);
    apb(1'b1, OFS_CONFIG, 32'h1);
    apb(1'b1, OFS_CTRL, ctl(OP_SUB_EXIT, 3'h0, 7'h00, 8'h00));
    apb(1'b1, OFS_PC, 32'h123);
    chk({31'h0, err}, 32'h1);
    do apb(1'b0, OFS_STATUS, 32'h0); while (rdat[0] !== 1'b0);
    rd_chk(OFS_PC, 32'h2468A);
    $display("test refusals done");
    give_verdict();
  end
endmodule : branch_skip_call_control_test
`default_nettype wire
